// [design/adc_ctrl_pkg.sv]
// constants and types shared by the converter control block
package adc_ctrl_pkg;
    localparam int RES_W = 16;
    localparam int CODE_W = 10;
    localparam logic [9:0] FULL_SCALE = 10'h3FF;
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [4:0] TEMP_CHANNEL = 5'h1E;
    localparam logic [2:0] WIN_OFF = 3'h0;
    localparam logic [2:0] WIN_BELOW = 3'h1;
    localparam logic [2:0] WIN_ABOVE = 3'h2;
    localparam logic [2:0] WIN_INSIDE = 3'h3;
    localparam logic [2:0] WIN_OUTSIDE = 3'h4;
    localparam logic [2:0] ACC_RESERVED = 3'h7;
    localparam logic [7:0] VEC_RESULT_READY = 8'h00;
    localparam logic [7:0] VEC_WINDOW = 8'h02;
    localparam logic [8:0] CONV_CYCLES = 9'h00D;
    localparam logic [8:0] INIT_DLY_STEP = 9'h010;
    localparam int CLK_MHZ = 125;
    localparam int TEMP_SETTLE_US = 32;
    localparam int TEMP_SETTLE_CYC = TEMP_SETTLE_US * CLK_MHZ;
    typedef enum {ST_IDLE, ST_DELAY, ST_CONV} conv_state_e;
endpackage

// [design/window_if.sv]
// carrier between the sequencer and the window comparator
`timescale 1ns/10ps
interface window_if;
    logic [2:0] mode;
    logic [15:0] result;
    logic [15:0] low;
    logic [15:0] high;
    logic hit;
    modport ctrl (output mode, output result, output low, output high, input hit);
    modport cmp (input mode, input result, input low, input high, output hit);
endinterface

// [design/window_cmp.sv]
// window comparator: unsigned strict compare against two thresholds
`timescale 1ns/10ps
module window_cmp (
    window_if.cmp win
);
    import adc_ctrl_pkg::*;
    wire below_low = win.result < win.low;
    wire above_high = win.result > win.high;
    wire above_low = win.result > win.low;
    wire below_high = win.result < win.high;
    wire hit_below = (win.mode == WIN_BELOW) && below_low;
    wire hit_above = (win.mode == WIN_ABOVE) && above_high;
    wire hit_inside = (win.mode == WIN_INSIDE) && above_low && below_high;
    wire hit_outside = (win.mode == WIN_OUTSIDE) && (below_low || above_high);
    assign win.hit = hit_below || hit_above || hit_inside || hit_outside;
endmodule

// [design/adc_window_compare_sleep_ctrl.sv]
// sequencing, accumulation, window check, flags and sleep handling of the converter
`timescale 1ns/10ps
module adc_window_compare_sleep_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // configuration
    input wire logic enable_i,
    input wire logic free_run_i,
    input wire logic run_in_standby_i,
    input wire logic resolution_select_i,
    input wire logic [2:0] accumulation_count_i,
    input wire logic [1:0] reference_select_i,
    input wire logic [2:0] prescaler_i,
    input wire logic [2:0] initial_delay_i,
    input wire logic [4:0] sample_length_i,
    input wire logic [4:0] positive_input_select_i,
    input wire logic [2:0] window_compare_mode_i,
    input wire logic [adc_ctrl_pkg::RES_W-1:0] window_low_threshold_i,
    input wire logic [adc_ctrl_pkg::RES_W-1:0] window_high_threshold_i,
    input wire logic start_event_input_enable_i,
    // software commands and interrupt control
    input wire logic start_conversion_write_i,
    input wire logic result_read_i,
    input wire logic result_ready_clear_i,
    input wire logic window_compare_clear_i,
    input wire logic result_ready_int_en_i,
    input wire logic window_compare_int_en_i,
    // sleep controller
    input wire logic standby_i,
    input wire logic power_down_i,
    // analog core and event system, asynchronous
    input wire logic [adc_ctrl_pkg::CODE_W-1:0] sample_code_i,
    input wire logic over_reference_i,
    input wire logic start_event_i,
    // status and results
    output logic start_conversion_bit_o,
    output logic result_ready_flag_o,
    output logic window_compare_flag_o,
    output logic result_valid_o,
    output logic [adc_ctrl_pkg::RES_W-1:0] result_o,
    output logic result_ready_irq_o,
    output logic window_compare_irq_o,
    output logic [7:0] result_ready_vector_o,
    output logic [7:0] window_compare_vector_o,
    // analog and clock control
    output logic internal_ref_select_o,
    output logic temp_sensor_enable_o,
    output logic sample_strobe_o,
    output logic clock_request_o
);
    import adc_ctrl_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    function automatic logic [7:0] presc_top(input logic [2:0] p);
        presc_top = 8'((9'h002 << p) - 9'h001);
    endfunction

    conv_state_e state_reg, state_next;
    logic [7:0] presc_reg;
    logic [8:0] cyc_reg;
    logic [6:0] samp_reg;
    logic [RES_W-1:0] acc_reg;
    logic [RES_W-1:0] result_reg;
    logic conv_bit_reg, rr_flag_reg, win_flag_reg, valid_reg, halted_reg;
    logic ref_int_reg, temp_en_reg, strobe_reg;
    logic [CODE_W-1:0] code_s1, code_s2;
    logic over_s1, over_s2, ev_s1, ev_s2, ev_s3;

    window_if win ();
    window_cmp u_window_cmp (.win(win));

    wire standby_stop = standby_i && !run_in_standby_i;
    wire active = enable_i && !power_down_i && !standby_stop;
    wire busy = state_reg != ST_IDLE;
    wire adc_tick = active && busy && (presc_reg == presc_top(prescaler_i));

    // rising edge of the synchronised event
    wire ev_rise = ev_s2 && !ev_s3;
    wire ev_start = start_event_input_enable_i && ev_rise;
    wire sw_start = start_conversion_write_i && !standby_i;
    wire start = enable_i && !busy && (ev_start || sw_start);

    // reserved count behaves as a single sample
    wire [2:0] acc_code = (accumulation_count_i == ACC_RESERVED) ? 3'h0 : accumulation_count_i;
    wire [6:0] samp_last = 7'((8'h01 << acc_code) - 8'h01);
    // first conversion waits the initial delay
    wire [8:0] dly_last = 9'(initial_delay_i * INIT_DLY_STEP - 9'h001);
    wire [8:0] conv_last = CONV_CYCLES + 9'(sample_length_i) - 9'h001;

    wire [CODE_W-1:0] code_sat = over_s2 ? FULL_SCALE : code_s2;
    wire [RES_W-1:0] sample_val = resolution_select_i ? {8'h00, code_sat[9:2]} : {6'h00, code_sat};
    wire take = (state_reg == ST_CONV) && adc_tick && (cyc_reg == conv_last);
    wire [RES_W-1:0] acc_sum = acc_reg + sample_val;
    wire done = take && (samp_reg == samp_last);
    wire restart = done && free_run_i;

    // only the final accumulated value is compared
    assign win.mode = window_compare_mode_i;
    assign win.result = acc_sum;
    assign win.low = window_low_threshold_i;
    assign win.high = window_high_threshold_i;

    // flags independent of enables; set wins over clear
    wire rr_flag_next = done || (rr_flag_reg && !(result_ready_clear_i || result_read_i));
    wire win_flag_next = (done && win.hit) || (win_flag_reg && !window_compare_clear_i);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = (initial_delay_i != 3'h0) ? ST_DELAY : ST_CONV;
                end
            end
            ST_DELAY: begin
                if (adc_tick && cyc_reg == dly_last) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (done && !restart) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (!enable_i) begin
            state_next = ST_IDLE;
        end
    end

    // analog and event pins cross in through two flops
    always_ff @(posedge clk_i) begin
        code_s1 <= sample_code_i;
        code_s2 <= code_s1;
        over_s1 <= over_reference_i;
        over_s2 <= over_s1;
        ev_s1 <= start_event_i;
        ev_s2 <= ev_s1;
        ev_s3 <= ev_s2;
    end

    // prescaler held at zero while idle gives a fixed start delay
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !busy || adc_tick) begin
            presc_reg <= 8'h00;
        end else if (active) begin
            presc_reg <= presc_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            cyc_reg <= 9'h000;
            samp_reg <= 7'h00;
            acc_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (start || state_next != state_reg || take) begin
                cyc_reg <= 9'h000;
            end else if (adc_tick) begin
                cyc_reg <= cyc_reg + 9'h001;
            end
            if (start || done) begin
                samp_reg <= 7'h00;
                acc_reg <= 16'h0000;
            end else if (take) begin
                samp_reg <= samp_reg + 7'h01;
                acc_reg <= acc_sum;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            conv_bit_reg <= 1'b0;
            rr_flag_reg <= 1'b0;
            win_flag_reg <= 1'b0;
            result_reg <= 16'h0000;
            valid_reg <= 1'b0;
            halted_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            // start bit stands for the whole conversion
            conv_bit_reg <= start || (conv_bit_reg && enable_i && !(done && !restart));
            // store result and raise ready flag
            if (done) begin
                result_reg <= acc_sum;
            end
            rr_flag_reg <= rr_flag_next;
            win_flag_reg <= win_flag_next;
            // a conversion frozen by power-down yields a bad result
            if (start || done) begin
                halted_reg <= 1'b0;
            end else if (busy && power_down_i) begin
                halted_reg <= 1'b1;
            end
            if (done) begin
                valid_reg <= !(halted_reg || power_down_i);
            end
            strobe_reg <= take;
        end
    end

    // selections are buffered and only follow the inputs between conversions
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ref_int_reg <= 1'b1;
            temp_en_reg <= 1'b0;
        end else if (!busy) begin
            ref_int_reg <= reference_select_i == REF_INTERNAL;
            // temperature channel turns on the sensor
            temp_en_reg <= positive_input_select_i == TEMP_CHANNEL;
        end
    end

    assign start_conversion_bit_o = conv_bit_reg;
    assign result_ready_flag_o = rr_flag_reg;
    assign window_compare_flag_o = win_flag_reg;
    assign result_valid_o = valid_reg;
    assign result_o = result_reg;
    // request while flag and enable both set
    assign result_ready_irq_o = rr_flag_reg && result_ready_int_en_i;
    assign window_compare_irq_o = win_flag_reg && window_compare_int_en_i;
    assign result_ready_vector_o = VEC_RESULT_READY;
    assign window_compare_vector_o = VEC_WINDOW;
    assign internal_ref_select_o = ref_int_reg;
    assign temp_sensor_enable_o = temp_en_reg;
    assign sample_strobe_o = strobe_reg;
    // clock held while the start bit is set in standby, also when the conversion is frozen without run in standby
    assign clock_request_o = standby_i && conv_bit_reg;

    ready_on_done_a: assert property (done |=> result_ready_flag_o)
        else $error("ready flag not set after completion");
    win_cause_a: assert property ($rose(window_compare_flag_o) |-> $past(done) && $past(win.mode) != WIN_OFF)
        else $error("window flag rose without a compared result");
    win_set_a: assert property (done && win.hit |=> window_compare_flag_o)
        else $error("window hit lost");
    inside_hit_a: assert property (win.hit && win.mode == WIN_INSIDE |->
        win.result > win.low && win.result < win.high)
        else $error("inside hit outside the window");
    outside_hit_a: assert property (win.hit && win.mode == WIN_OUTSIDE |->
        win.result < win.low || win.result > win.high)
        else $error("outside hit inside the window");
    event_start_a: assert property (ev_start && enable_i && !busy |=> start_conversion_bit_o ##1 busy)
        else $error("event did not start a conversion");
    irq_hold_a: assert property ($fell(result_ready_irq_o) |-> !result_ready_int_en_i ||
        $past(result_ready_clear_i || result_read_i))
        else $error("ready request dropped while flag set");
    standby_halt_a: assert property (standby_stop && busy |=> $stable(cyc_reg) && $stable(acc_reg))
        else $error("sequencer ran in standby");
    done_clear_a: assert property (done && !free_run_i |=> !start_conversion_bit_o)
        else $error("start bit not cleared at completion");
    full_scale_a: assert property (over_s2 && !resolution_select_i |-> sample_val == 16'h03FF)
        else $error("over-range sample not saturated");
    eight_bit_a: assert property (resolution_select_i |-> sample_val[15:8] == 8'h00)
        else $error("eight-bit sample too wide");
    temp_enable_a: assert property (!busy && positive_input_select_i == TEMP_CHANNEL |=> temp_sensor_enable_o)
        else $error("temperature sensor not enabled");
    accum_once_a: assert property (take && !done |=> !$rose(window_compare_flag_o))
        else $error("window flag raised before the last sample");
    delay_first_a: assert property (start && initial_delay_i != 3'h0 |=> state_reg == ST_DELAY)
        else $error("initial delay skipped");
    power_freeze_a: assert property (busy && power_down_i |=> $stable(cyc_reg) && $stable(samp_reg))
        else $error("sequencer ran in power-down");
    clock_release_a: assert property (done && !free_run_i |=> !clock_request_o)
        else $error("clock request held after completion");
    ready_hold_a: assert property (result_ready_flag_o && !result_ready_clear_i && !result_read_i |=> result_ready_flag_o)
        else $error("ready flag dropped without a clear");
endmodule

// [testbench/adc_analog_model.sv]
// analog core and event source model facing the converter control
`timescale 1ns/10ps
module adc_analog_model (
    // clock
    input wire logic clk_i,
    // bench control
    input wire logic [9:0] level_i,
    input wire logic over_i,
    input wire logic fire_i,
    // toward the converter
    output logic [9:0] sample_code_o,
    output logic over_reference_o,
    output logic start_event_o
);
    logic [2:0] hold_reg = 3'h0;
    assign sample_code_o = level_i;
    assign over_reference_o = over_i;
    // event held several cycles so the two-flop synchroniser sees it
    always_ff @(posedge clk_i) begin
        if (fire_i) begin
            hold_reg <= 3'h5;
        end else if (hold_reg != 3'h0) begin
            hold_reg <= hold_reg - 3'h1;
        end
    end
    assign start_event_o = hold_reg != 3'h0;
endmodule

// [testbench/test_adc_window_compare_sleep_ctrl.sv]
// self-checking bench for the converter control block
`timescale 1ns/10ps
module test_adc_window_compare_sleep_ctrl;
    import adc_ctrl_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, enable_i = 1'b1, free_run_i = 1'b0, run_in_standby_i = 1'b0;
    logic resolution_select_i = 1'b0, start_event_input_enable_i = 1'b0, start_conversion_write_i = 1'b0;
    logic result_read_i = 1'b0, result_ready_clear_i = 1'b0, window_compare_clear_i = 1'b0;
    logic result_ready_int_en_i = 1'b0, window_compare_int_en_i = 1'b0, standby_i = 1'b0, power_down_i = 1'b0;
    logic [2:0] accumulation_count_i = 3'h0, prescaler_i = 3'h0, initial_delay_i = 3'h0, window_compare_mode_i = 3'h0;
    logic [1:0] reference_select_i = 2'h0;
    logic [4:0] sample_length_i = 5'h00, positive_input_select_i = 5'h00;
    logic [15:0] window_low_threshold_i = 16'h0100, window_high_threshold_i = 16'h0200;
    logic [9:0] level = 10'h000, sample_code;
    logic over = 1'b0, fire = 1'b0, over_reference, start_event;
    logic start_conversion_bit_o, result_ready_flag_o, window_compare_flag_o, result_valid_o;
    logic result_ready_irq_o, window_compare_irq_o, internal_ref_select_o, temp_sensor_enable_o;
    logic sample_strobe_o, clock_request_o;
    logic [15:0] result_o;
    logic [7:0] result_ready_vector_o, window_compare_vector_o;
    int bad_count = 0, checks = 0, cyc = 0, n0 = 0, n1 = 0, strobes = 0;
    adc_analog_model i_model (.clk_i, .level_i(level), .over_i(over), .fire_i(fire),
        .sample_code_o(sample_code), .over_reference_o(over_reference), .start_event_o(start_event));
    adc_window_compare_sleep_ctrl i_dut (.clk_i, .sys_rst_i, .enable_i, .free_run_i, .run_in_standby_i,
        .resolution_select_i, .accumulation_count_i, .reference_select_i, .prescaler_i, .initial_delay_i,
        .sample_length_i, .positive_input_select_i, .window_compare_mode_i, .window_low_threshold_i,
        .window_high_threshold_i, .start_event_input_enable_i, .start_conversion_write_i, .result_read_i,
        .result_ready_clear_i, .window_compare_clear_i, .result_ready_int_en_i, .window_compare_int_en_i,
        .standby_i, .power_down_i, .sample_code_i(sample_code), .over_reference_i(over_reference),
        .start_event_i(start_event), .start_conversion_bit_o, .result_ready_flag_o, .window_compare_flag_o,
        .result_valid_o, .result_o, .result_ready_irq_o, .window_compare_irq_o, .result_ready_vector_o,
        .window_compare_vector_o, .internal_ref_select_o, .temp_sensor_enable_o, .sample_strobe_o,
        .clock_request_o);
    always #4 clk_i = ~clk_i;
    // ceiling well above the few thousand cycles the sequence needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            stop_test();
        end
    end
    // strobes counted on the falling edge, clear of the launching edge
    always @(negedge clk_i) begin
        if (sample_strobe_o === 1'b1) begin
            strobes++;
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic compare(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic wait_ready(output int n);
        n = 0;
        while (result_ready_flag_o !== 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        compare("ready in time", result_ready_flag_o, 16'h0001);
    endtask
    task automatic pulse_start();
        @(negedge clk_i);
        start_conversion_write_i = 1'b1;
        @(negedge clk_i);
        start_conversion_write_i = 1'b0;
    endtask
    task automatic sw_conv(output int n);
        pulse_start();
        wait_ready(n);
    endtask
    task automatic pulse_event();
        @(negedge clk_i);
        fire = 1'b1;
        @(negedge clk_i);
        fire = 1'b0;
    endtask
    task automatic clear_flags();
        @(negedge clk_i);
        result_ready_clear_i = 1'b1;
        window_compare_clear_i = 1'b1;
        result_read_i = 1'b1;
        @(negedge clk_i);
        result_ready_clear_i = 1'b0;
        window_compare_clear_i = 1'b0;
        result_read_i = 1'b0;
        idle(1);
    endtask
    function automatic logic win_exp(input logic [2:0] m, input logic [15:0] r);
        logic lo;
        logic hi;
        lo = r < window_low_threshold_i;
        hi = r > window_high_threshold_i;
        case (m)
            WIN_BELOW: return lo;
            WIN_ABOVE: return hi;
            WIN_INSIDE: return r > window_low_threshold_i && r < window_high_threshold_i;
            WIN_OUTSIDE: return lo || hi;
            default: return 1'b0;
        endcase
    endfunction
    task automatic t_single();
        level = 10'h155;
        sw_conv(n0);
        compare("result", result_o, 16'h0155);
        compare("ready flag", result_ready_flag_o, 16'h0001);
        compare("valid", result_valid_o, 16'h0001);
        compare("start bit", start_conversion_bit_o, 16'h0000);
        compare("ready irq off", result_ready_irq_o, 16'h0000);
        result_ready_int_en_i = 1'b1;
        #1 compare("ready irq on", result_ready_irq_o, 16'h0001);
        compare("ready vector", result_ready_vector_o, VEC_RESULT_READY);
        compare("window vector", window_compare_vector_o, VEC_WINDOW);
        clear_flags();
        compare("ready irq cleared", result_ready_irq_o, 16'h0000);
        result_ready_int_en_i = 1'b0;
        over = 1'b1;
        sw_conv(n0);
        compare("full scale", result_o, {6'h00, FULL_SCALE});
        over = 1'b0;
        clear_flags();
    endtask
    task automatic t_window();
        logic [9:0] codes [5] = '{10'h0FF, 10'h100, 10'h155, 10'h200, 10'h201};
        logic hit;
        window_compare_int_en_i = 1'b1;
        for (int m = 0; m < 6; m++) begin
            for (int c = 0; c < 5; c++) begin
                window_compare_mode_i = 3'(m);
                level = codes[c];
                sw_conv(n0);
                hit = win_exp(3'(m), {6'h00, codes[c]});
                compare("window flag", window_compare_flag_o, {15'h0000, hit});
                compare("window irq", window_compare_irq_o, {15'h0000, hit});
                clear_flags();
            end
        end
        window_compare_int_en_i = 1'b0;
    endtask
    task automatic t_accum();
        logic [15:0] sum;
        int s0;
        window_compare_mode_i = WIN_BELOW;
        level = 10'h010;
        for (int k = 0; k < 8; k++) begin
            accumulation_count_i = 3'(k);
            sum = (k == 7) ? 16'h0010 : 16'h0010 << k;
            s0 = strobes;
            sw_conv(n0);
            compare("accumulated", result_o, sum);
            compare("window on sum", window_compare_flag_o, sum < 16'h0100);
            clear_flags();
            compare("sample strobes", 16'(strobes - s0), sum >> 4);
        end
        resolution_select_i = 1'b1;
        accumulation_count_i = 3'h1;
        level = 10'h3FF;
        sw_conv(n0);
        compare("eight bit sum", result_o, 16'h01FE);
        clear_flags();
        resolution_select_i = 1'b0;
        accumulation_count_i = 3'h0;
        window_compare_mode_i = WIN_OFF;
    endtask
    task automatic t_events();
        pulse_event();
        idle(40);
        compare("event disabled", start_conversion_bit_o, 16'h0000);
        start_event_input_enable_i = 1'b1;
        pulse_event();
        idle(8);
        compare("event start", start_conversion_bit_o, 16'h0001);
        wait_ready(n0);
        compare("event done", start_conversion_bit_o, 16'h0000);
        clear_flags();
        standby_i = 1'b1;
        run_in_standby_i = 1'b1;
        pulse_start();
        idle(40);
        compare("sw start in standby", start_conversion_bit_o, 16'h0000);
        pulse_event();
        idle(8);
        compare("clock request", clock_request_o, 16'h0001);
        wait_ready(n0);
        compare("standby ready", result_ready_flag_o, 16'h0001);
        compare("clock released", clock_request_o, 16'h0000);
        clear_flags();
        run_in_standby_i = 1'b0;
        pulse_event();
        idle(200);
        compare("standby stopped", result_ready_flag_o, 16'h0000);
        standby_i = 1'b0;
        wait_ready(n0);
        clear_flags();
        start_event_input_enable_i = 1'b0;
    endtask
    task automatic t_sleep_delay();
        pulse_start();
        idle(10);
        power_down_i = 1'b1;
        idle(200);
        compare("halted flag", result_ready_flag_o, 16'h0000);
        compare("halted busy", start_conversion_bit_o, 16'h0001);
        power_down_i = 1'b0;
        wait_ready(n0);
        compare("resumed flag", result_ready_flag_o, 16'h0001);
        compare("invalid result", result_valid_o, 16'h0000);
        clear_flags();
        sw_conv(n0);
        clear_flags();
        initial_delay_i = 3'h1;
        sw_conv(n1);
        compare("delay cycles", 16'(n1 - n0), 16'h0020);
        clear_flags();
        positive_input_select_i = TEMP_CHANNEL;
        reference_select_i = REF_INTERNAL;
        idle(3);
        compare("temp sensor", temp_sensor_enable_o, 16'h0001);
        compare("internal ref", internal_ref_select_o, 16'h0001);
        reference_select_i = 2'h1;
        idle(3);
        compare("supply ref", internal_ref_select_o, 16'h0000);
        reference_select_i = REF_INTERNAL;
        initial_delay_i = 3'h7;
        sample_length_i = 5'h1F;
        sw_conv(n0);
        compare("temp reading", result_ready_flag_o, 16'h0001);
        clear_flags();
    endtask
    // free-running conversions carried on into standby
    task automatic t_free_run();
        free_run_i = 1'b1;
        sw_conv(n0);
        compare("free-run bit", start_conversion_bit_o, 16'h0001);
        standby_i = 1'b1;
        run_in_standby_i = 1'b1;
        clear_flags();
        wait_ready(n0);
        compare("free-run standby", clock_request_o, 16'h0001);
        free_run_i = 1'b0;
        clear_flags();
        wait_ready(n0);
        compare("free-run stop", start_conversion_bit_o, 16'h0000);
        compare("clock off", clock_request_o, 16'h0000);
        clear_flags();
        standby_i = 1'b0;
        run_in_standby_i = 1'b0;
    endtask
    initial begin
        idle(10);
        sys_rst_i = 1'b0;
        idle(3);
        compare("reset ready", result_ready_flag_o, 16'h0000);
        compare("reset ref", internal_ref_select_o, 16'h0001);
        compare("reset temp", temp_sensor_enable_o, 16'h0000);
        t_single();
        t_window();
        t_accum();
        t_events();
        t_free_run();
        t_sleep_delay();
        stop_test();
    end
endmodule
